// file: rtl/p2m_defs.svh
// p2m_defs.svh: register offsets, field positions, reset values and thresholds
// assumes: included by bare name from the mux top and its testbench
`ifndef P2M_DEFS_SVH
`define P2M_DEFS_SVH

// =====================================================================
// register byte offsets on the apb slave
`define P2M_OFF_INPUT    8'h00
`define P2M_OFF_OUTPUT   8'h04
`define P2M_OFF_DIR      8'h08
`define P2M_OFF_FSEL     8'h0c
`define P2M_OFF_IFLAG    8'h10
`define P2M_OFF_IEN      8'h14
`define P2M_OFF_IEDGE    8'h18
`define P2M_OFF_APD      8'h1c
`define P2M_OFF_SUPV     8'h20
`define P2M_OFF_DPC      8'h24
`define P2M_OFF_ISTAT    8'h28
`define P2M_OFF_IMASK    8'h2c

// =====================================================================
// field positions and values
`define P2M_LVL_HI       7
`define P2M_LVL_LO       4
`define P2M_LVL_ALL_ONES 4'hf
`define P2M_DPC_HI       3
`define P2M_DPC_LO       0
`define P2M_DPC_SEG_MIN  4'h4
`define P2M_APD_MASK     8'h3c
`define P2M_PIN_MASK     8'h3f
`define P2M_SW_ONLY_MASK 8'hc0

// =====================================================================
// reset values
`define P2M_RST_BYTE     8'h00
`define P2M_RST_DPC      4'h0

`endif

// file: rtl/p2m_pkg.sv
// p2m_pkg.sv: types shared by the port 2 function mux
// assumes: nothing outside itself
package p2m_pkg;

   // =====================================================================
   // per-pin drive mode, one-hot
   typedef enum logic [3:0] {
      P2M_MODE_OFF    = 4'b0001,
      P2M_MODE_PORT   = 4'b0010,
      P2M_MODE_MODULE = 4'b0100,
      P2M_MODE_SEG    = 4'b1000
   } p2m_mode_t;

   typedef logic [7:0] p2m_byte_t;

endpackage : p2m_pkg

// file: rtl/p2m_sync.sv
// p2m_sync.sv: two flip-flop synchroniser for a bus of independent levels
// assumes: each bit is a slow level; no bus coherence is needed
`timescale 1ns/1ps
`default_nettype none

module p2m_sync #(
   parameter int W = 6
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // =====================================================================
   // first stage feeds only the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule : p2m_sync

`default_nettype wire

// file: rtl/p2m_edge_flag.sv
// p2m_edge_flag.sv: interrupt flags with edge detection and software write
// assumes: lvl is synchronous to pclk; hw_en marks bits that own a pin
`timescale 1ns/1ps
`default_nettype none

module p2m_edge_flag #(
   parameter int W = 8
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] lvl,
   input  wire logic [W-1:0] edge_fall,
   input  wire logic [W-1:0] hw_en,
   input  wire logic         wr,
   input  wire logic [W-1:0] wdata,
   output var  logic [W-1:0] flag_q
);

   logic [W-1:0] prev_q;
   logic         primed_q;
   logic [W-1:0] hit;
   logic [W-1:0] flag_d;

   // =====================================================================
   // edge match per bit; first cycle after reset only loads history
   assign hit    = {W{primed_q}} & hw_en &
                   ((~edge_fall & lvl & ~prev_q) | (edge_fall & ~lvl & prev_q));
   // a hardware set wins over a software clear in the same cycle
   assign flag_d = (wr ? wdata : flag_q) | hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q   <= '0;
         primed_q <= 1'b0;
         flag_q   <= '0;
      end else begin
         prev_q   <= lvl;
         primed_q <= 1'b1;
         flag_q   <= flag_d;
      end
   end

endmodule : p2m_edge_flag

`default_nettype wire

// file: rtl/p2m_port2_mux.sv
// p2m_port2_mux.sv: port 2 pin function selection, port registers and interrupts
// assumes: apb master on pclk; pins asynchronous; serial peripheral on pclk
//
// Implementation choices: the placing of the registers and the APB slave port.
`include "p2m_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module p2m_port2_mux (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata_q,
   output var  logic        pready_q,
   output var  logic        pslverr_q,
   input  wire logic [5:0]  pin_in,
   output var  logic [5:0]  pin_out_q,
   output var  logic [5:0]  pin_oe_q,
   input  wire logic [1:0]  module_out_b01,
   input  wire logic [1:0]  segment_data,
   input  wire logic        async_tx_data,
   output var  logic        slave_transmit_enable_q,
   output var  logic        async_rx_data_q,
   output var  logic        port_irq_q,
   output var  logic        summary_irq_q
);

   // =====================================================================
   // register state
   p2m_pkg::p2m_byte_t output_latch_q, direction_reg_q, function_select_q;
   p2m_pkg::p2m_byte_t irq_enable_q, edge_select_q, apd_reg_q;
   p2m_pkg::p2m_byte_t supv_ctl_q, irq_status_q, irq_mask_q;
   p2m_pkg::p2m_byte_t irq_flag;
   logic [3:0]         display_port_control_q;

   // =====================================================================
   // apb decode
   logic     setup_ph;
   logic     acc_ph;
   logic     wr_en;
   logic     rd_en;
   logic     hit_any;
   logic [7:0] wb;
   logic     wr_out, wr_dir, wr_fsel, wr_flag, wr_ien, wr_edge;
   logic     wr_apd, wr_supv, wr_dpc, wr_mask, rd_stat;

   assign setup_ph = psel & ~penable;
   assign acc_ph   = psel & penable & pready_q;
   assign wr_en    = acc_ph & pwrite & ~pslverr_q;
   assign rd_en    = acc_ph & ~pwrite;
   assign wb       = pwdata[7:0];
   assign wr_out   = wr_en & (paddr == `P2M_OFF_OUTPUT);
   assign wr_dir   = wr_en & (paddr == `P2M_OFF_DIR);
   assign wr_fsel  = wr_en & (paddr == `P2M_OFF_FSEL);
   assign wr_flag  = wr_en & (paddr == `P2M_OFF_IFLAG);
   assign wr_ien   = wr_en & (paddr == `P2M_OFF_IEN);
   assign wr_edge  = wr_en & (paddr == `P2M_OFF_IEDGE);
   assign wr_apd   = wr_en & (paddr == `P2M_OFF_APD);
   assign wr_supv  = wr_en & (paddr == `P2M_OFF_SUPV);
   assign wr_dpc   = wr_en & (paddr == `P2M_OFF_DPC);
   assign wr_mask  = wr_en & (paddr == `P2M_OFF_IMASK);
   assign rd_stat  = rd_en & (paddr == `P2M_OFF_ISTAT);

   // =====================================================================
   // pin synchroniser
   logic [5:0] pin_s;

   p2m_sync #(.W(6)) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       (pin_in),
      .q       (pin_s)
   );

   // =====================================================================
   // port activity per bit
   logic [7:0] apd_eff;
   logic       seg_mode;
   logic [5:0] active;

   // supervisor level all ones forces bit 3 disabled
   assign apd_eff  = (apd_reg_q & `P2M_APD_MASK) |
                     {4'h0, (supv_ctl_q[`P2M_LVL_HI:`P2M_LVL_LO] == `P2M_LVL_ALL_ONES),
                      3'h0};
   assign seg_mode = (display_port_control_q >= `P2M_DPC_SEG_MIN);
   assign active   = {~apd_eff[5:2], {2{~seg_mode}}};

   // =====================================================================
   // per-pin mode and drive
   logic [5:0] out_d;
   logic [5:0] oe_d;
   logic [5:0] mod_out;
   logic [5:0] mod_oe;
   p2m_pkg::p2m_mode_t mode [6];

   // module side: bit 2 in, bit 3 dir reg, bit 4 out, bit 5 in
   assign mod_out = {1'b0, async_tx_data, 1'b0, 1'b0, module_out_b01};
   assign mod_oe  = {1'b0, 1'b1, direction_reg_q[3], 1'b0,
                     direction_reg_q[1:0]};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_pin
         assign mode[gi] = !active[gi] ? ((gi < 2) ? p2m_pkg::P2M_MODE_SEG
                                                   : p2m_pkg::P2M_MODE_OFF) :
                           function_select_q[gi] ? p2m_pkg::P2M_MODE_MODULE :
                                                   p2m_pkg::P2M_MODE_PORT;
         // select clear: latch under direction register
         assign out_d[gi] = (mode[gi] == p2m_pkg::P2M_MODE_PORT)   ? output_latch_q[gi] :
                            (mode[gi] == p2m_pkg::P2M_MODE_MODULE) ? mod_out[gi] :
                            (mode[gi] == p2m_pkg::P2M_MODE_SEG)    ? segment_data[gi % 2] :
                                                                     1'b0;
         assign oe_d[gi]  = (mode[gi] == p2m_pkg::P2M_MODE_PORT)   ? direction_reg_q[gi] :
                            (mode[gi] == p2m_pkg::P2M_MODE_MODULE) ? mod_oe[gi] :
                            (mode[gi] == p2m_pkg::P2M_MODE_SEG);
      end
   endgenerate

   // =====================================================================
   // input value: pins gated by activity, bits 6 and 7 read low
   logic [7:0] input_value;

   assign input_value = {2'b00, pin_s & active};

   // =====================================================================
   // interrupt flags; bits 6 and 7 have no hardware source
   p2m_edge_flag #(.W(8)) u_flag (
      .pclk      (pclk),
      .presetn   (presetn),
      .lvl       (input_value),
      .edge_fall (edge_select_q),
      .hw_en     (`P2M_PIN_MASK),
      .wr        (wr_flag),
      .wdata     (wb),
      .flag_q    (irq_flag)
   );

   // =====================================================================
   // request, sticky status and mask
   logic [7:0] irq_req;
   logic [7:0] stat_clr;
   logic [7:0] stat_d;

   assign irq_req  = irq_flag & irq_enable_q;
   // clear only the bits that the read returned; new events win
   assign stat_clr = rd_stat ? prdata_q[7:0] : 8'h00;
   assign stat_d   = (irq_status_q & ~stat_clr) | irq_req;

   // =====================================================================
   // read mux
   logic [7:0] rd_byte;
   logic       addr_ok;

   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `P2M_OFF_IMASK);
   assign rd_byte = (paddr == `P2M_OFF_INPUT)  ? input_value :
                    (paddr == `P2M_OFF_OUTPUT) ? output_latch_q :
                    (paddr == `P2M_OFF_DIR)    ? direction_reg_q :
                    (paddr == `P2M_OFF_FSEL)   ? function_select_q :
                    (paddr == `P2M_OFF_IFLAG)  ? irq_flag :
                    (paddr == `P2M_OFF_IEN)    ? irq_enable_q :
                    (paddr == `P2M_OFF_IEDGE)  ? edge_select_q :
                    (paddr == `P2M_OFF_APD)    ? apd_eff :
                    (paddr == `P2M_OFF_SUPV)   ? supv_ctl_q :
                    (paddr == `P2M_OFF_DPC)    ? {4'h0, display_port_control_q} :
                    (paddr == `P2M_OFF_ISTAT)  ? irq_status_q :
                    (paddr == `P2M_OFF_IMASK)  ? irq_mask_q : 8'h00;
   assign hit_any = addr_ok;

   // =====================================================================
   // apb answer: ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup_ph;
         pslverr_q <= setup_ph & ~hit_any;
         if (setup_ph) begin
            prdata_q <= {24'h00_0000, rd_byte};
         end
      end
   end

   // =====================================================================
   // software registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_latch_q         <= `P2M_RST_BYTE;
         direction_reg_q        <= `P2M_RST_BYTE;
         function_select_q      <= `P2M_RST_BYTE;
         irq_enable_q           <= `P2M_RST_BYTE;
         edge_select_q          <= `P2M_RST_BYTE;
         apd_reg_q              <= `P2M_RST_BYTE;
         supv_ctl_q             <= `P2M_RST_BYTE;
         irq_mask_q             <= `P2M_RST_BYTE;
         display_port_control_q <= `P2M_RST_DPC;
      end else begin
         if (wr_out)  output_latch_q    <= wb;
         if (wr_dir)  direction_reg_q   <= wb;
         if (wr_fsel) function_select_q <= wb;
         if (wr_ien)  irq_enable_q      <= wb;
         if (wr_edge) edge_select_q     <= wb;
         if (wr_apd)  apd_reg_q         <= wb & `P2M_APD_MASK;
         if (wr_supv) supv_ctl_q        <= wb;
         if (wr_mask) irq_mask_q        <= wb;
         if (wr_dpc)  display_port_control_q <= wb[`P2M_DPC_HI:`P2M_DPC_LO];
      end
   end

   // =====================================================================
   // registered pin drive, module feeds and interrupt outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out_q               <= 6'h00;
         pin_oe_q                <= 6'h00;
         slave_transmit_enable_q <= 1'b1;
         async_rx_data_q         <= 1'b1;
         irq_status_q            <= `P2M_RST_BYTE;
         port_irq_q              <= 1'b0;
         summary_irq_q           <= 1'b0;
      end else begin
         pin_out_q               <= out_d;
         pin_oe_q                <= oe_d;
         slave_transmit_enable_q <= (mode[2] == p2m_pkg::P2M_MODE_MODULE) ? pin_s[2] : 1'b1;
         async_rx_data_q         <= (mode[5] == p2m_pkg::P2M_MODE_MODULE) ? pin_s[5] : 1'b1;
         irq_status_q            <= stat_d;
         port_irq_q              <= |irq_req;
         summary_irq_q           <= |(stat_d & irq_mask_q);
      end
   end

   // =====================================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready_q;
   endsequence
   // one-cycle level steps of the bit 0 input as the flag logic sees them
   sequence s_rise0;
      input_value[0] && !$past(input_value[0]);
   endsequence
   sequence s_fall0;
      !input_value[0] && $past(input_value[0]);
   endsequence

   apb_answer_a: assert property (s_setup ##1 (psel && penable) |-> pready_q)
      else $error("apb access phase not answered in one cycle");
   apd_blocks_drive_a: assert property (apd_eff[4] |=> !pin_oe_q[4] && !pin_out_q[4])
      else $error("disabled pin still driven");
   ste_route_a: assert property (active[2] && function_select_q[2]
      |=> !pin_oe_q[2] && !pin_out_q[2] && slave_transmit_enable_q == $past(pin_s[2]))
      else $error("bit 2 module routing wrong");
   bit3_dir_a: assert property (active[3] && function_select_q[3]
      |=> pin_oe_q[3] == $past(direction_reg_q[3]) && !pin_out_q[3])
      else $error("bit 3 module drive wrong");
   // input is cut in the same cycle; the registered drive follows one edge later
   supv_force_a: assert property (supv_ctl_q[`P2M_LVL_HI:`P2M_LVL_LO] == `P2M_LVL_ALL_ONES
      |-> !input_value[3] ##1 !pin_oe_q[3])
      else $error("supervisor level did not block bit 3");
   tx_drive_a: assert property (active[4] && function_select_q[4]
      |=> pin_oe_q[4] && pin_out_q[4] == $past(async_tx_data))
      else $error("bit 4 not driving transmit data");
   rx_route_a: assert property (active[5] && function_select_q[5]
      |=> !pin_oe_q[5] && async_rx_data_q == $past(pin_s[5]))
      else $error("bit 5 receive routing wrong");
   // pinless flags hold unless software writes the flag register
   sw_flag_only_a: assert property (!wr_flag |=> $stable(irq_flag[7:6]))
      else $error("bits 6 or 7 flag changed without a write");
   req_gate_a: assert property (port_irq_q == $past(|(irq_flag & irq_enable_q)))
      else $error("interrupt request not gated by enable");
   // segment input is cut at once, the drive one edge later
   seg_mode_a: assert property (seg_mode |-> !input_value[0] ##1 pin_oe_q[1:0] == 2'b11)
      else $error("bits 0 and 1 not in segment mode");
   edge_set_a: assert property ((s_rise0 ##0 !edge_select_q[0]) |=> irq_flag[0])
      else $error("rising edge did not set flag");

   // falling edges, software writes of the pinless flags and the pinless input bits
   edge_fall_a: assert property ((s_fall0 ##0 edge_select_q[0]) |=> irq_flag[0])
      else $error("falling edge did not set flag");
   sw_flag_write_a: assert property (wr_flag |=> irq_flag[7:6] == $past(wb[7:6]))
      else $error("bits 6 or 7 flag did not take the written value");
   pinless_in_a: assert property (input_value[7:6] == 2'b00)
      else $error("pinless bits read a level");

   // cut-off pins and plain port drive
   cut_drive_a: assert property (!active[5] |=> !pin_oe_q[5] && !pin_out_q[5])
      else $error("cut-off bit 5 still driven");
   cut_input_a: assert property (!active[2] |-> !input_value[2])
      else $error("cut-off bit 2 input not low");
   port_drive_a: assert property (active[0] && !function_select_q[0]
      |=> pin_oe_q[0] == $past(direction_reg_q[0]) && pin_out_q[0] == $past(output_latch_q[0]))
      else $error("bit 0 port drive wrong");

   // segment drive and idle module feeds
   seg_drive_a: assert property (seg_mode |=> pin_out_q[1:0] == $past(segment_data))
      else $error("segment data not driven");
   ste_idle_a: assert property (!(active[2] && function_select_q[2])
      |=> slave_transmit_enable_q)
      else $error("idle slave transmit enable not high");
   rx_idle_a: assert property (!(active[5] && function_select_q[5])
      |=> async_rx_data_q)
      else $error("idle receive feed not high");

   // sticky status and summary request
   stat_sticky_a: assert property (|irq_req
      |=> (irq_status_q & $past(irq_req)) == $past(irq_req))
      else $error("status bit missed a request");
   rd_clear_a: assert property (rd_stat
      |=> (irq_status_q & $past(prdata_q[7:0] & ~irq_req)) == 8'h00)
      else $error("status read did not clear returned bits");
   sum_level_a: assert property ((irq_status_q & irq_mask_q) != 8'h00 && !rd_stat
      |=> summary_irq_q)
      else $error("summary request low with unmasked status");

   // bus writes land at the access edge; unmapped addresses are refused
   wr_lands_a: assert property ((s_access ##0 (pwrite && paddr == `P2M_OFF_DIR))
      |=> direction_reg_q == $past(pwdata[7:0]))
      else $error("direction write did not land");
   err_answer_a: assert property ((s_setup ##0 !addr_ok) |=> pready_q && pslverr_q)
      else $error("unmapped address not refused");

endmodule : p2m_port2_mux

`default_nettype wire

// file: dv/p2m_far_side.sv
// p2m_far_side.sv: pins and serial peripheral beyond the port 2 function mux
// assumes: bench sets the outside line levels; device drive wins on its own pins
`timescale 1ns/1ps
`default_nettype none

module p2m_far_side (
   input  wire logic       pclk,
   input  wire logic [5:0] ext_lvl,
   input  wire logic [5:0] pin_out_q,
   input  wire logic [5:0] pin_oe_q,
   output var  logic [5:0] pin_in,
   output var  logic       async_tx_data
);
   logic [2:0] cnt_q = 3'h0;

   // =====================================================================
   // pin wires
   // a driven pin shows the device level, an undriven one the outside level
   assign pin_in = (pin_oe_q & pin_out_q) | (~pin_oe_q & ext_lvl);

   // =====================================================================
   // serial transmit stream
   // transmit data keeps changing so a stuck pin output shows up
   always @(posedge pclk) begin
      cnt_q <= cnt_q + 3'h1;
   end
   assign async_tx_data = cnt_q[1] ^ cnt_q[2];
endmodule : p2m_far_side
`default_nettype wire

// file: dv/p2m_port2_mux_tb.sv
// p2m_port2_mux_tb.sv: self-checking bench of the port 2 function mux
// assumes: design answers each apb access with a one-cycle pready_q pulse
`timescale 1ns/1ps
`default_nettype none
`include "p2m_defs.svh"

module p2m_port2_mux_tb;
   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata_q;
   logic        pready_q, pslverr_q;
   logic [5:0]  pin_in, pin_out_q, pin_oe_q, ext_lvl;
   logic [1:0]  mob, seg;
   logic        txd, tx_d, ste, rxd, port_irq, sum_irq;
   int          mismatches = 0;
   int          checks_done = 0;

   // =====================================================================
   // clock, design and far side
   always #10 pclk = ~pclk;
   always @(posedge pclk) tx_d <= txd;

   p2m_port2_mux dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
      .pready_q(pready_q), .pslverr_q(pslverr_q), .pin_in(pin_in), .pin_out_q(pin_out_q),
      .pin_oe_q(pin_oe_q), .module_out_b01(mob), .segment_data(seg), .async_tx_data(txd),
      .slave_transmit_enable_q(ste), .async_rx_data_q(rxd), .port_irq_q(port_irq),
      .summary_irq_q(sum_irq));

   p2m_far_side far (.pclk(pclk), .ext_lvl(ext_lvl), .pin_out_q(pin_out_q),
      .pin_oe_q(pin_oe_q), .pin_in(pin_in), .async_tx_data(txd));

   // =====================================================================
   // helpers
   task automatic wrap_up;
      if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // one apb transfer; entered and left right after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_q !== 1'b1 && n < 20);
      r = prdata_q;
      e = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk(1'b0, 1'b1, "no pready");
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp, m);
   endtask : rd

   // expected input register: wire level on active port bits, 0 where cut off
   function automatic logic [31:0] exp_in(input logic [5:0] oe, input logic [5:0] o,
                                          input logic [5:0] x, input logic [5:0] dis);
      return {26'h0, ((oe & o) | (~oe & x)) & ~dis};
   endfunction : exp_in

   // =====================================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      wrap_up();
   end

   // =====================================================================
   // main sequence
   initial begin
      logic [31:0] r;
      logic        e;
      int          i;
      logic [7:0]  dir, outv, apd;
      logic [5:0]  oe;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      ext_lvl = 6'h00;
      mob = 2'h0;
      seg = 2'h0;
      i = $urandom(32'hccd017a9);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({ste, rxd, pin_oe_q}, 8'hc0, "idle feeds");
      for (i = 4; i <= 'h2c; i += 4) rd(i[7:0], 32'h0, "reset value");
      apb(1'b0, 8'h30, 32'h0, r, e);
      chk({e, r[30:0]}, 32'h8000_0000, "unmapped");
      // random port traffic with analog disable
      for (i = 0; i < 8; i++) begin
         dir = 8'($urandom);
         outv = 8'($urandom);
         apd = 8'($urandom) & `P2M_APD_MASK;
         ext_lvl <= 6'($urandom);
         wr(`P2M_OFF_DIR, dir);
         wr(`P2M_OFF_OUTPUT, outv);
         wr(`P2M_OFF_APD, apd);
         repeat (6) @(posedge pclk);
         oe = dir[5:0] & ~apd[5:0];
         chk(pin_oe_q, oe, "oe");
         chk(pin_out_q & oe, outv[5:0] & oe, "out");
         apb(1'b0, `P2M_OFF_INPUT, 32'h0, r, e);
         chk(r & 32'h3f, exp_in(oe, outv[5:0], ext_lvl, apd[5:0]), "in");
      end
      // supervisor level all ones cuts bit 3 off
      wr(`P2M_OFF_APD, 8'h00);
      wr(`P2M_OFF_DIR, 8'h3c);
      wr(`P2M_OFF_SUPV, 8'hf0);
      repeat (3) @(posedge pclk);
      chk(pin_oe_q[3], 1'b0, "lvl oe");
      rd(`P2M_OFF_APD, 32'h08, "lvl apd");
      wr(`P2M_OFF_SUPV, 8'he0);
      repeat (3) @(posedge pclk);
      chk(pin_oe_q[3], 1'b1, "lvl off");
      // module functions on bits 2..5
      wr(`P2M_OFF_FSEL, 8'h3c);
      wr(`P2M_OFF_DIR, 8'h00);
      repeat (3) @(posedge pclk);
      chk(pin_oe_q[5:2], 4'b0100, "mod dir0");
      wr(`P2M_OFF_DIR, 8'hff);
      ext_lvl <= 6'h00;
      repeat (6) @(posedge pclk);
      chk({pin_oe_q[5:2], pin_out_q[3], ste, rxd}, 7'b0110000, "mod lo");
      ext_lvl <= 6'h24;
      repeat (6) @(posedge pclk);
      chk({pin_out_q[2], pin_out_q[5], ste, rxd}, 4'b0011, "mod hi");
      for (i = 0; i < 8; i++) begin
         @(posedge pclk);
         #1;
         chk(pin_out_q[4], tx_d, "tx");
      end
      @(posedge pclk);
      ext_lvl <= 6'h00;
      wr(`P2M_OFF_FSEL, 8'h00);
      // display control threshold on bits 0 and 1
      wr(`P2M_OFF_DIR, 8'h03);
      wr(`P2M_OFF_OUTPUT, 8'h00);
      for (i = 0; i < 16; i++) begin
         seg <= 2'($urandom) | 2'b01;
         wr(`P2M_OFF_DPC, i[7:0]);
         repeat (3) @(posedge pclk);
         chk({pin_oe_q[1:0], pin_out_q[1:0]}, {2'b11, (i >= 4) ? seg : 2'b00}, "dpc");
      end
      wr(`P2M_OFF_DPC, 8'h00);
      mob <= 2'b10;
      wr(`P2M_OFF_FSEL, 8'h03);
      repeat (3) @(posedge pclk);
      chk(pin_out_q[1:0], 2'b10, "b01 module");
      wr(`P2M_OFF_FSEL, 8'h00);
      wr(`P2M_OFF_DIR, 8'h00);
      wr(`P2M_OFF_IFLAG, 8'h00);
      // pin edges, enables, software flags
      ext_lvl <= 6'h3f;
      repeat (8) @(posedge pclk);
      rd(`P2M_OFF_IFLAG, 32'h3f, "rise flags");
      chk(port_irq, 1'b0, "irq disabled");
      wr(`P2M_OFF_IEN, 8'hff);
      repeat (2) @(posedge pclk);
      chk(port_irq, 1'b1, "irq enabled");
      wr(`P2M_OFF_IFLAG, 8'h00);
      rd(`P2M_OFF_IFLAG, 32'h0, "flag clear");
      wr(`P2M_OFF_IEDGE, 8'h15);
      ext_lvl <= 6'h00;
      repeat (8) @(posedge pclk);
      rd(`P2M_OFF_IFLAG, 32'h15, "fall flags");
      wr(`P2M_OFF_IFLAG, 8'hc0);
      rd(`P2M_OFF_IFLAG, 32'hc0, "sw flags");
      chk({port_irq, sum_irq}, 2'b10, "masked");
      wr(`P2M_OFF_IMASK, 8'h80);
      repeat (2) @(posedge pclk);
      chk(sum_irq, 1'b1, "summary");
      wr(`P2M_OFF_IFLAG, 8'h00);
      rd(`P2M_OFF_ISTAT, 32'hff, "status");
      rd(`P2M_OFF_ISTAT, 32'h00, "status cleared");
      repeat (2) @(posedge pclk);
      chk({port_irq, sum_irq}, 2'b00, "irq low");
      wrap_up();
   end
endmodule : p2m_port2_mux_tb
`default_nettype wire
